/* File: aux_adc_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// - 8-bit successive-approximation converter for slow diagnostic measurements.
// - select code 0 connects no input; codes 1 to 4 connect inputs 0 to 3.
// - write to the converter register with bit 15 set starts a conversion.
// - each conversion lasts exactly 8704 master clock cycles from trigger.
// - on completion, done flag reads at bit 15, result at bits 7 to 0.
// - optional interrupt when a conversion completes, avoiding polling.
module aux_adc_ctrl
  import aux_adc_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEFAULT
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic [6:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  input  wire logic        COMP_IN,
  output logic      [7:0]  DAC_CODE,
  output logic      [3:0]  ANALOG_INPUT_EN,
  output logic             CONV_BUSY,
  input  wire logic        IRQ_EN,
  output logic             IRQ
);

  // one enable per analog input; codes above 4 connect nothing
  function automatic logic [3:0] sel_onehot(input logic [3:0] sel);
    logic [3:0] hot;
    hot = 4'h0;
    for (int i = 0; i < INPUT_COUNT; i++) begin
      if (sel == 4'(i + 1)) begin
        hot[i] = 1'b1;
      end
    end
    return hot;
  endfunction

  aux_sar_if sar_link ();

  logic       reg_hit;
  logic       trig;
  logic [3:0] input_sel;
  logic       done_flag;

  assign reg_hit        = (REG_ADDR == AUX_REG_ADDR);
  assign trig           = REG_WR && reg_hit && REG_WDATA[TRIG_BIT];
  assign sar_link.start = trig;
  assign sar_link.comp  = COMP_IN;

  aux_sar_engine #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_engine (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .sar   (sar_link)
  );

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      input_sel       <= SEL_RESET;
      ANALOG_INPUT_EN <= 4'h0;
    end else if (REG_WR && reg_hit) begin
      input_sel       <= REG_WDATA[SEL_MSB:SEL_LSB];
      ANALOG_INPUT_EN <= sel_onehot(REG_WDATA[SEL_MSB:SEL_LSB]);
    end
  end

  // clear on trigger; a retrigger abandons the running conversion
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      done_flag <= 1'b0;
    end else if (trig) begin
      done_flag <= 1'b0;
    end else if (sar_link.finish) begin
      done_flag <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= sar_link.finish && !trig && IRQ_EN;
    end
  end

  // read back flag, select and result
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      REG_RDATA <= RDATA_RESET;
    end else if (REG_RD) begin
      REG_RDATA <= 16'h0000;
      if (reg_hit) begin
        REG_RDATA[DONE_BIT]                <= done_flag;
        REG_RDATA[SEL_MSB:SEL_LSB]         <= input_sel;
        REG_RDATA[RESULT_MSB:RESULT_LSB]   <= sar_link.result;
      end
    end
  end

  // mirrors so every output leaves from a flop in this module
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      DAC_CODE  <= 8'h00;
      CONV_BUSY <= 1'b0;
    end else begin
      DAC_CODE  <= sar_link.code;
      CONV_BUSY <= sar_link.busy || trig;
    end
  end

  // cycles since the last trigger, for checking only
  logic [15:0] since_trig;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      since_trig <= 16'h0000;
    end else if (trig) begin
      // zero at the trigger edge so the finish pulse sees the full count
      since_trig <= 16'h0000;
    end else if (since_trig != 16'hffff) begin
      since_trig <= since_trig + 16'h0001;
    end
  end

  AST_SEL_DECODE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REG_WR && reg_hit) |=> ANALOG_INPUT_EN == sel_onehot($past(REG_WDATA[SEL_MSB:SEL_LSB])))
    else $error("input enables do not match written select");

  AST_ONE_INPUT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $onehot0(ANALOG_INPUT_EN))
    else $error("more than one analog input connected");

  AST_TRIG_STARTS: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    trig |=> sar_link.busy ##1 CONV_BUSY)
    else $error("trigger did not start a conversion");

  AST_CONV_LENGTH: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    sar_link.finish |-> since_trig == 16'(CONV_CYCLES))
    else $error("conversion length wrong");

  AST_DONE_SET: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (sar_link.finish && !trig) |=> done_flag)
    else $error("done flag not set at completion");

  AST_RESULT_READ: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REG_RD && reg_hit) |=>
      REG_RDATA[RESULT_MSB:RESULT_LSB] == $past(sar_link.result)
      && REG_RDATA[DONE_BIT] == $past(done_flag))
    else $error("read data does not show result and flag");

  AST_IRQ_PULSE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (sar_link.finish && !trig && IRQ_EN) |=> IRQ ##1 !IRQ)
    else $error("completion interrupt missing or too long");

  AST_DONE_CLEARED: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    trig |=> !done_flag throughout (sar_link.busy [*8]))
    else $error("done flag high during conversion");

  AST_DONE_LOW_BUSY: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    sar_link.busy |-> !done_flag)
    else $error("done flag high while busy");

  AST_UNMAPPED_READ: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REG_RD && !reg_hit) |=> REG_RDATA == 16'h0000)
    else $error("read of another address not zero");

  AST_SEL_READBACK: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REG_RD && reg_hit) |=> REG_RDATA[SEL_MSB:SEL_LSB] == $past(input_sel))
    else $error("select field does not read back");

  AST_IRQ_CAUSE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    IRQ |-> $past(sar_link.finish && IRQ_EN))
    else $error("interrupt without an enabled completion");

  AST_IRQ_MASKED: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (sar_link.finish && !IRQ_EN) |=> !IRQ)
    else $error("interrupt raised while disabled");

  AST_DONE_HOLDS: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (done_flag && !trig) |=> done_flag)
    else $error("done flag dropped without a trigger");

  AST_DONE_CAUSE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(done_flag) |-> $past(sar_link.finish))
    else $error("done flag rose without a completion");

  AST_BUSY_ENDS: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    sar_link.finish |-> !sar_link.busy)
    else $error("engine still busy at completion");

  AST_NO_IDLE_FINISH: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !sar_link.busy |=> !sar_link.finish)
    else $error("completion without a running conversion");

  AST_DAC_TRIAL: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(CONV_BUSY) |-> ##1 DAC_CODE == SAR_FIRST_TRIAL)
    else $error("first trial code not on the converter");

  AST_EN_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REG_WR && !reg_hit) |=> $stable(ANALOG_INPUT_EN))
    else $error("input enables moved on a foreign write");

  AST_SEL_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !(REG_WR && reg_hit) |=> $stable(input_sel))
    else $error("select moved without a write");

  AST_RESULT_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !$stable(sar_link.result) |-> sar_link.finish)
    else $error("result changed outside a completion");

  COV_FULL_CONV: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    trig ##1 sar_link.busy ##[1:1000] sar_link.finish);
  COV_FINISH_IRQ: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    sar_link.finish && IRQ_EN);
  COV_RETRIGGER: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    sar_link.busy && trig);
  COV_READ_DONE: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    REG_RD && reg_hit && done_flag);

endmodule

/* File: aux_adc_pkg.sv */
package aux_adc_pkg;
  localparam logic [6:0]  AUX_REG_ADDR        = 7'h27;
  localparam int          TRIG_BIT            = 15;
  localparam int          DONE_BIT            = 15;
  localparam int          SEL_MSB             = 11;
  localparam int          SEL_LSB             = 8;
  localparam int          RESULT_MSB          = 7;
  localparam int          RESULT_LSB          = 0;
  localparam int          RESULT_BITS         = 8;
  localparam int          INPUT_COUNT         = 4;
  localparam int          CONV_CYCLES_DEFAULT = 8704;
  localparam logic [3:0]  SEL_RESET           = 4'h0;
  localparam logic [7:0]  SAR_FIRST_TRIAL     = 8'h80;
  localparam logic [15:0] RDATA_RESET         = 16'h0000;
endpackage

/* File: aux_sar_engine.sv */
`timescale 1ns/1ps
module aux_sar_engine
  import aux_adc_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEFAULT
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  aux_sar_if.engine  sar
);
  // each of the eight trials gets an equal share of the conversion time
  localparam int          BIT_CYCLES = CONV_CYCLES / RESULT_BITS;
  localparam logic [15:0] BIT_LAST   = 16'(BIT_CYCLES - 1);

  logic [15:0] phase_cnt;
  logic [2:0]  bit_ptr;
  logic [7:0]  next_code;

  // keep the trial bit when the input sits at or above the trial level
  always_comb begin
    next_code = sar.code;
    if (!sar.comp) begin
      next_code[bit_ptr] = 1'b0;
    end
    if (bit_ptr != 3'd0) begin
      next_code[bit_ptr - 3'd1] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sar.busy  <= 1'b0;
      sar.code  <= 8'h00;
      phase_cnt <= 16'h0000;
      bit_ptr   <= 3'd7;
    end else if (sar.start) begin
      sar.busy  <= 1'b1;
      sar.code  <= SAR_FIRST_TRIAL;
      phase_cnt <= 16'h0000;
      bit_ptr   <= 3'd7;
    end else if (sar.busy) begin
      if (phase_cnt == BIT_LAST) begin
        phase_cnt <= 16'h0000;
        sar.code  <= next_code;
        bit_ptr   <= bit_ptr - 3'd1;
        if (bit_ptr == 3'd0) begin
          sar.busy <= 1'b0;
        end
      end else begin
        phase_cnt <= phase_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sar.finish <= 1'b0;
      sar.result <= 8'h00;
    end else begin
      sar.finish <= 1'b0;
      if (!sar.start && sar.busy && phase_cnt == BIT_LAST && bit_ptr == 3'd0) begin
        sar.finish <= 1'b1;
        sar.result <= next_code;
      end
    end
  end

  AST_SAR_FIRST_TRIAL: assert property (@(posedge clk) disable iff (!rst_n)
    sar.start |=> (sar.code == SAR_FIRST_TRIAL) && sar.busy)
    else $error("first trial is not mid scale");
endmodule

/* File: aux_sar_if.sv */
`timescale 1ns/1ps
interface aux_sar_if;
  logic       start;
  logic       comp;
  logic [7:0] code;
  logic       busy;
  logic       finish;
  logic [7:0] result;
  modport ctrl (output start, output comp, input code, input busy, input finish, input result);
  modport engine (input start, input comp, output code, output busy, output finish, output result);
endinterface

/* File: tb_aux_adc_ctrl.sv */
`timescale 1ns/1ps
module tb_aux_adc_ctrl;
  import aux_adc_pkg::*;
  localparam int CONV = 64;
  logic        CLK_SYS, RST_N, REG_WR, REG_RD, COMP_IN, IRQ_EN;
  logic [6:0]  REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA, d;
  logic [7:0]  DAC_CODE, target, lfsr, t;
  logic [3:0]  ANALOG_INPUT_EN, sel;
  logic        CONV_BUSY, IRQ;
  int          num_errors, n_compared, irq_cnt, irq_base, t0, cyc;
  aux_adc_ctrl #(.CONV_CYCLES(CONV)) u_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .COMP_IN(COMP_IN), .DAC_CODE(DAC_CODE),
    .ANALOG_INPUT_EN(ANALOG_INPUT_EN), .CONV_BUSY(CONV_BUSY), .IRQ_EN(IRQ_EN), .IRQ(IRQ));
  initial begin
    CLK_SYS = 0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  // comparator stands in for the analog input at level target
  always @(posedge CLK_SYS) begin
    COMP_IN <= (target >= DAC_CODE);
    if (!RST_N) irq_cnt <= 0;
    else if (IRQ === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  // one-hot enable for a select code; codes outside 1..4 connect nothing
  function automatic logic [15:0] exp_en(input int s);
    return (s >= 1 && s <= INPUT_COUNT) ? 16'(1 << (s - 1)) : 16'h0000;
  endfunction
  function automatic logic [7:0] next_rand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    @(posedge CLK_SYS);
    REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= v;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [6:0] a);
    @(posedge CLK_SYS);
    REG_RD <= 1'b1; REG_ADDR <= a;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  // one conversion with polling; done must not show early
  task automatic conv(input logic [7:0] v, input logic [3:0] s, input logic ie);
    target = v;
    irq_base = irq_cnt;
    @(posedge CLK_SYS);
    IRQ_EN <= ie;
    wr(AUX_REG_ADDR, {1'b1, 3'h0, s, 8'h00});
    t0 = $time / 40;
    rd(AUX_REG_ADDR);
    check(16'(d[15]), 16'h0);
    for (int i = 0; i < CONV; i++) begin
      rd(AUX_REG_ADDR);
      if (d[15] === 1'b1) break;
    end
    if (d[15] !== 1'b1) begin
      num_errors++;
      summarize();
    end
    cyc = $time / 40 - t0;
    check(16'(cyc > CONV && cyc <= CONV + 5), 16'h1);
    check(d, {1'b1, 3'h0, s, v});
    check(16'(irq_cnt - irq_base), 16'(ie));
    $display("conversion %h done", v);
  endtask
  initial begin
    RST_N = 0; REG_WR = 0; REG_RD = 0; REG_ADDR = 0; REG_WDATA = 0;
    IRQ_EN = 0;
    target = 0;
    lfsr = 8'h5d;
    num_errors = 0;
    n_compared = 0;
    repeat (6) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    rd(AUX_REG_ADDR);
    check(d, RDATA_RESET);
    for (int s = 0; s < 7; s++) begin
      wr(AUX_REG_ADDR, 16'(s) << 8);
      check(16'(ANALOG_INPUT_EN), exp_en(s));
    end
    $display("select test done");
    wr(7'h28, 16'h8400);
    check(16'(ANALOG_INPUT_EN), 16'h0);
    check(16'(CONV_BUSY), 16'h0);
    rd(7'h26);
    check(d, 16'h0);
    $display("unmapped test done");
    for (int k = 0; k < 9; k++) begin
      lfsr = next_rand(lfsr);
      t = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : (k == 2) ? 8'h80 : (k == 3) ? 8'h7f : lfsr;
      sel = 4'(1 + lfsr[1:0]);
      conv(t, sel, lfsr[2]);
      check(16'(ANALOG_INPUT_EN), exp_en(int'(sel)));
    end
    // restart mid-conversion: old run must never finish
    target = 8'h33;
    wr(AUX_REG_ADDR, 16'h8100);
    repeat (CONV / 2) @(posedge CLK_SYS);
    conv(8'hc5, 4'h3, 1'b1);
    summarize();
  end
  initial begin
    #1000000;
    num_errors++;
    summarize();
  end
endmodule
